// ### hw/cps_pkg.sv
package cps_pkg;
   // =========================================================
   // register map and field layout
   localparam logic [7:0]  CPS_OFS_CTRL   = 8'h00;
   localparam logic [7:0]  CPS_OFS_DIV    = 8'h04;
   localparam logic [7:0]  CPS_OFS_STAT   = 8'h08;
   localparam logic [7:0]  CPS_OFS_TX0    = 8'h10;
   localparam logic [7:0]  CPS_OFS_TX1    = 8'h14;
   localparam logic [7:0]  CPS_OFS_RX0    = 8'h20;
   localparam logic [7:0]  CPS_OFS_RX1    = 8'h24;
   localparam logic [7:0]  CPS_OFS_RX2    = 8'h28;
   localparam logic [7:0]  CPS_OFS_RX3    = 8'h2c;
   localparam int          CPS_DIV_REC    = 8;
   localparam int          CPS_ST_RFRM    = 8;
   localparam int          CPS_ST_OEN     = 16;
   localparam int          CPS_ST_IEN     = 20;
   localparam logic [7:0]  CPS_CTRL_RST   = 8'h00;
   localparam logic [15:0] CPS_DIV_RST    = 16'h0202;
   // =========================================================
   // frame geometry
   localparam logic [4:0]  CPS_SLOT_LAST  = 5'h1f;
   localparam logic [4:0]  CPS_WORD_MAX   = 5'h18;
   localparam logic [5:0]  CPS_TX_COPY    = 6'h30;
   // =========================================================
   // port modes, one-hot
   typedef enum logic [3:0] {
      CPS_OFF   = 4'b0001,
      CPS_I2S4  = 4'b0010,
      CPS_I2S5  = 4'b0100,
      CPS_PULSE = 4'b1000
   } cps_mode_t;
   // software control byte
   typedef struct packed {
      logic       crst;
      logic       sreq;
      logic       pmst;
      logic       byte_order_reverse;
      logic [1:0] wid;
      logic [1:0] mode;
   } cps_ctrl_t;
   // configuration carried into the link domain
   typedef struct packed {
      cps_ctrl_t  ctrl;
      logic [7:0] div_r;
      logic [7:0] div_p;
   } cps_cfg_t;
endpackage : cps_pkg

// ### hw/cps_codec_port.sv
`timescale 1ns/100ps

// =========================================================
// bit clock and bit index generator, link domain
module cps_bit_gen (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [7:0] half,
   input  wire logic       resync,
   output logic            bclk_r,
   output logic            fall_r,
   output logic [5:0]      idx_r,
   output logic            frm_r
);
   logic [7:0] cnt_r;
   logic       expire;
   logic [5:0] idx_nxt;

   // half period of zero acts as one
   assign expire  = ({1'b0, cnt_r} + 9'd1) >= {1'b0, half};
   assign idx_nxt = resync ? 6'd1 : idx_r + 6'd1;

   // index advances on each falling edge, wraps at 64
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r  <= 8'h00;
         bclk_r <= 1'b0;
         fall_r <= 1'b0;
         idx_r  <= 6'h00;
         frm_r  <= 1'b0;
      end else if (!run) begin
         cnt_r  <= 8'h00;
         bclk_r <= 1'b0;
         fall_r <= 1'b0;
         idx_r  <= 6'h00;
      end else begin
         fall_r <= 1'b0;
         if (expire) begin
            cnt_r  <= 8'h00;
            bclk_r <= ~bclk_r;
            if (bclk_r) begin
               fall_r <= 1'b1;
               idx_r  <= idx_nxt;
               if (idx_nxt == 6'h00) frm_r <= ~frm_r;
            end
         end else begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end
endmodule : cps_bit_gen

// =========================================================
// codec port, stereo and pulse modes
module cps_codec_port (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  port_master_clk,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [31:0]                reg_rdata,
   output logic                       port_sync_pin_o,
   output logic                       port_sync_pin_oe_n,
   input  wire logic                  port_sync_pin_i,
   output logic                       port_bit_clock_pin,
   output logic                       port_data_out_pin,
   input  wire logic                  port_data_in_pin,
   output logic                       port_codec_reset_pin,
   output logic                       secondary_channel_pin_o,
   output logic                       secondary_channel_pin_oe_n,
   input  wire logic                  secondary_channel_pin_i
);
   import cps_pkg::*;

   function automatic cps_mode_t dec_mode(input logic [1:0] m);
      case (m)
         2'd1:    dec_mode = CPS_I2S4;
         2'd2:    dec_mode = CPS_I2S5;
         2'd3:    dec_mode = CPS_PULSE;
         default: dec_mode = CPS_OFF;
      endcase
   endfunction : dec_mode

   // words sit msb-aligned at bit 23
   function automatic logic [23:0] wmask(input logic [1:0] w);
      case (w)
         2'd0:    wmask = 24'hffff00;
         2'd1:    wmask = 24'hffffc0;
         2'd2:    wmask = 24'hfffff0;
         default: wmask = 24'hffffff;
      endcase
   endfunction : wmask

   function automatic logic [23:0] bswap(input logic [23:0] w, input logic en);
      bswap = en ? {w[7:0], w[15:8], w[23:16]} : w;
   endfunction : bswap

   // =========================================================
   // system domain: registers
   cps_ctrl_t    ctrl_r;
   logic [15:0]  div_r;
   logic [23:0]  tx_r [2];
   logic [23:0]  tx_x_r [2];
   logic [23:0]  rx_s_r [4];
   logic [7:0]   pcnt_r;
   logic [7:0]   rcnt_r;
   logic         pt_m_r, pt_s_r, pt_d_r;
   logic         rt_m_r, rt_s_r, rt_d_r;
   cps_mode_t    mode_s;
   logic         p_edge, r_edge, rx_edge;
   logic [1:0]   oen;
   logic [3:0]   ien;

   // link-domain products read here
   logic         p_frm, r_frm;
   logic [23:0]  rx_a_r [2];
   logic [23:0]  rx_b_r [2];

   assign mode_s  = dec_mode(ctrl_r.mode);
   assign p_edge  = pt_s_r ^ pt_d_r;
   assign r_edge  = rt_s_r ^ rt_d_r;
   assign rx_edge = (mode_s == CPS_I2S5) ? r_edge : p_edge;

   // slot enables seen by the dma side
   always_comb begin
      oen = 2'b00;
      ien = 4'b0000;
      case (mode_s)
         CPS_I2S4:  begin oen = 2'b11; ien = 4'b1111; end
         CPS_I2S5:  begin oen = 2'b11; ien = 4'b0011; end
         CPS_PULSE: begin oen = 2'b01; ien = 4'b0001; end
         default:   begin oen = 2'b00; ien = 4'b0000; end
      endcase
   end

   // software writes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_r   <= CPS_CTRL_RST;
         div_r    <= CPS_DIV_RST;
         tx_r[0]  <= 24'h000000;
         tx_r[1]  <= 24'h000000;
      end else if (reg_wr) begin
         case (reg_addr)
            CPS_OFS_CTRL: ctrl_r  <= reg_wdata[7:0];
            CPS_OFS_DIV:  div_r   <= reg_wdata[15:0];
            CPS_OFS_TX0:  tx_r[0] <= reg_wdata[23:0];
            CPS_OFS_TX1:  tx_r[1] <= reg_wdata[23:0];
            default: ;
         endcase
      end
   end

   // frame toggles from the link: level crossing, then edge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {pt_m_r, pt_s_r, pt_d_r} <= 3'b000;
         {rt_m_r, rt_s_r, rt_d_r} <= 3'b000;
      end else begin
         {pt_m_r, pt_s_r, pt_d_r} <= {p_frm, pt_m_r, pt_s_r};
         {rt_m_r, rt_s_r, rt_d_r} <= {r_frm, rt_m_r, rt_s_r};
      end
   end

   // one word handover per frame; link words stay put a whole frame
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tx_x_r[0] <= 24'h000000;
         tx_x_r[1] <= 24'h000000;
         pcnt_r    <= 8'h00;
      end else if (p_edge) begin
         tx_x_r[0] <= bswap(tx_r[0], ctrl_r.byte_order_reverse);
         tx_x_r[1] <= bswap(tx_r[1], ctrl_r.byte_order_reverse);
         pcnt_r    <= pcnt_r + 8'h01;
      end
   end

   // input slots to dma slots
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) rx_s_r[i] <= 24'h000000;
         rcnt_r <= 8'h00;
      end else if (rx_edge) begin
         rcnt_r    <= rcnt_r + 8'h01;
         rx_s_r[0] <= bswap(rx_a_r[0], ctrl_r.byte_order_reverse);
         if (mode_s == CPS_I2S4) begin
            rx_s_r[1] <= bswap(rx_b_r[0], ctrl_r.byte_order_reverse);
            rx_s_r[2] <= bswap(rx_a_r[1], ctrl_r.byte_order_reverse);
            rx_s_r[3] <= bswap(rx_b_r[1], ctrl_r.byte_order_reverse);
         end else begin
            rx_s_r[1] <= bswap(rx_a_r[1], ctrl_r.byte_order_reverse);
            rx_s_r[2] <= 24'h000000;
            rx_s_r[3] <= 24'h000000;
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            CPS_OFS_CTRL: reg_rdata <= {24'h000000, ctrl_r};
            CPS_OFS_DIV:  reg_rdata <= {16'h0000, div_r};
            CPS_OFS_STAT: reg_rdata <= {8'h00, ien, 2'b00, oen, rcnt_r, pcnt_r};
            CPS_OFS_TX0:  reg_rdata <= {8'h00, tx_r[0]};
            CPS_OFS_TX1:  reg_rdata <= {8'h00, tx_r[1]};
            CPS_OFS_RX0:  reg_rdata <= {8'h00, rx_s_r[0]};
            CPS_OFS_RX1:  reg_rdata <= {8'h00, rx_s_r[1]};
            CPS_OFS_RX2:  reg_rdata <= {8'h00, rx_s_r[2]};
            CPS_OFS_RX3:  reg_rdata <= {8'h00, rx_s_r[3]};
            default:      reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   // =========================================================
   // link domain
   cps_cfg_t    cfg_m_r, cfg_l_r;
   cps_mode_t   mode_l;
   logic        din_m_r, din_s_r, sec_m_r, sec_s_r, syn_m_r, syn_s_r;
   logic        p_bclk, p_fall, r_bclk, r_fall;
   logic [5:0]  p_idx, r_idx, a_idx, a_prev, b_prev;
   logic        a_fall, pulse_m;
   logic [23:0] tx_l_r [2];
   logic [23:0] sh_r, ra_sh_r, rb_sh_r;
   logic        sdo_r, fclk_p_r, fclk_r_r, syn_p_r;

   // config is quasi-static: change it only with the port off
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) begin
         cfg_m_r <= '0;
         cfg_l_r <= '0;
      end else begin
         cfg_m_r <= {ctrl_r, div_r};
         cfg_l_r <= cfg_m_r;
      end
   end

   // pin inputs pass two flops first
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) begin
         {din_m_r, din_s_r} <= 2'b00;
         {sec_m_r, sec_s_r} <= 2'b00;
         {syn_m_r, syn_s_r} <= 2'b00;
      end else begin
         {din_m_r, din_s_r} <= {port_data_in_pin, din_m_r};
         {sec_m_r, sec_s_r} <= {secondary_channel_pin_i, sec_m_r};
         {syn_m_r, syn_s_r} <= {port_sync_pin_i, syn_m_r};
      end
   end

   assign mode_l  = dec_mode(cfg_l_r.ctrl.mode);
   assign pulse_m = (mode_l == CPS_PULSE) && cfg_l_r.ctrl.pmst;

   // playback clocks; codec sync realigns in pulse master
   cps_bit_gen u_play (
      .clk    (port_master_clk),
      .rst    (rst),
      .run    (mode_l != CPS_OFF),
      .half   (cfg_l_r.div_p),
      .resync (pulse_m && syn_s_r),
      .bclk_r (p_bclk),
      .fall_r (p_fall),
      .idx_r  (p_idx),
      .frm_r  (p_frm)
   );

   // record clocks, separate rate in mode 5 only
   cps_bit_gen u_rec (
      .clk    (port_master_clk),
      .rst    (rst),
      .run    (mode_l == CPS_I2S5),
      .half   (cfg_l_r.div_r),
      .resync (1'b0),
      .bclk_r (r_bclk),
      .fall_r (r_fall),
      .idx_r  (r_idx),
      .frm_r  (r_frm)
   );

   assign a_fall = (mode_l == CPS_I2S5) ? r_fall : p_fall;
   assign a_idx  = (mode_l == CPS_I2S5) ? r_idx : p_idx;
   assign a_prev = a_idx - 6'd1;
   assign b_prev = p_idx - 6'd1;

   // link copy taken at bit 48 of the frame, far from the handover instant
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) begin
         tx_l_r[0] <= 24'h000000;
         tx_l_r[1] <= 24'h000000;
      end else if (p_fall && p_idx == CPS_TX_COPY) begin
         tx_l_r[0] <= tx_x_r[0];
         tx_l_r[1] <= tx_x_r[1];
      end
   end

   // transmit: audio only, no command slots on this line
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) begin
         sh_r     <= 24'h000000;
         sdo_r    <= 1'b0;
         fclk_p_r <= 1'b0;
         syn_p_r  <= 1'b0;
      end else if (mode_l == CPS_OFF) begin
         sh_r     <= 24'h000000;
         sdo_r    <= 1'b0;
         fclk_p_r <= 1'b0;
         syn_p_r  <= 1'b0;
      end else if (p_fall) begin
         fclk_p_r <= p_idx[5];
         syn_p_r  <= (p_idx == 6'h00);
         if (p_idx[4:0] == 5'h00) begin
            sdo_r <= 1'b0;
            if ((mode_l == CPS_PULSE) && p_idx[5]) sh_r <= 24'h000000;
            else sh_r <= tx_l_r[p_idx[5]] & wmask(cfg_l_r.ctrl.wid);
         end else begin
            sdo_r <= sh_r[23];
            sh_r  <= {sh_r[22:0], 1'b0};
         end
      end
   end

   // record frame clock on its own falling edges
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) fclk_r_r <= 1'b0;
      else if (mode_l != CPS_I2S5) fclk_r_r <= 1'b0;
      else if (r_fall) fclk_r_r <= r_idx[5];
   end

   // data-in pin: bit held over the rising edge, taken at the fall
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) begin
         ra_sh_r   <= 24'h000000;
         rx_a_r[0] <= 24'h000000;
         rx_a_r[1] <= 24'h000000;
      end else if (mode_l == CPS_OFF) begin
         ra_sh_r <= 24'h000000;
      end else if (a_fall) begin
         if (a_prev[4:0] != 5'h00 && a_prev[4:0] <= CPS_WORD_MAX)
            ra_sh_r <= {ra_sh_r[22:0], din_s_r};
         if (a_prev[4:0] == CPS_SLOT_LAST) begin
            rx_a_r[a_prev[5]] <= ra_sh_r & wmask(cfg_l_r.ctrl.wid);
            ra_sh_r <= 24'h000000;
         end
      end
   end

   // secondary input, mode 4 only
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) begin
         rb_sh_r   <= 24'h000000;
         rx_b_r[0] <= 24'h000000;
         rx_b_r[1] <= 24'h000000;
      end else if (mode_l != CPS_I2S4) begin
         rb_sh_r <= 24'h000000;
      end else if (p_fall) begin
         if (b_prev[4:0] != 5'h00 && b_prev[4:0] <= CPS_WORD_MAX)
            rb_sh_r <= {rb_sh_r[22:0], sec_s_r};
         if (b_prev[4:0] == CPS_SLOT_LAST) begin
            rx_b_r[b_prev[5]] <= rb_sh_r & wmask(cfg_l_r.ctrl.wid);
            rb_sh_r <= 24'h000000;
         end
      end
   end

   // pin mapping; one output stream only, no codec program line
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) begin
         port_sync_pin_o            <= 1'b0;
         port_sync_pin_oe_n         <= 1'b0;
         port_bit_clock_pin         <= 1'b0;
         port_data_out_pin          <= 1'b0;
         port_codec_reset_pin       <= 1'b0;
         secondary_channel_pin_o    <= 1'b0;
         secondary_channel_pin_oe_n <= 1'b1;
      end else begin
         port_sync_pin_o            <= 1'b0;
         port_sync_pin_oe_n         <= 1'b0;
         port_bit_clock_pin         <= p_bclk;
         port_data_out_pin          <= sdo_r;
         port_codec_reset_pin       <= cfg_l_r.ctrl.crst;
         secondary_channel_pin_o    <= 1'b0;
         secondary_channel_pin_oe_n <= 1'b1;
         case (mode_l)
            CPS_I2S4: begin
               port_sync_pin_o <= fclk_p_r;
            end
            CPS_I2S5: begin
               port_sync_pin_o            <= fclk_p_r;
               port_codec_reset_pin       <= r_bclk;
               secondary_channel_pin_o    <= fclk_r_r;
               secondary_channel_pin_oe_n <= 1'b0;
            end
            CPS_PULSE: begin
               port_sync_pin_o            <= syn_p_r;
               port_sync_pin_oe_n         <= cfg_l_r.ctrl.pmst;
               secondary_channel_pin_o    <= cfg_l_r.ctrl.sreq;
               secondary_channel_pin_oe_n <= 1'b0;
            end
            default: begin
               port_bit_clock_pin   <= 1'b0;
               port_data_out_pin    <= 1'b0;
               port_codec_reset_pin <= 1'b0;
            end
         endcase
      end
   end

   // =========================================================
   // checks, link domain
   default clocking cb @(posedge port_master_clk); endclocking
   default disable iff (rst);

   // cleared while off so the first bit after a restart counts from zero
   logic [5:0] last_idx_r;
   always_ff @(posedge port_master_clk or posedge rst) begin
      if (rst) last_idx_r <= 6'h00;
      else if (mode_l == CPS_OFF) last_idx_r <= 6'h00;
      else if (p_fall) last_idx_r <= p_idx;
   end

   sequence s_slot_start;
      p_fall && (p_idx[4:0] == 5'h00) && (mode_l != CPS_OFF);
   endsequence
   sequence s_pulse_start;
      p_fall && (p_idx == 6'h00) && (mode_l == CPS_PULSE);
   endsequence

   a_off_quiet: assert property ((mode_l == CPS_OFF) |=> ##1
      !port_sync_pin_o && !port_bit_clock_pin && !port_data_out_pin)
      else $error("pins active with port off");
   a_frame_edge: assert property ($changed(fclk_p_r) && !$past(mode_l == CPS_OFF)
      |-> $past(p_fall)) else $error("frame clock moved off a falling edge");
   a_data_edge: assert property ($changed(sdo_r) && !$past(mode_l == CPS_OFF)
      |-> $past(p_fall)) else $error("data changed off a falling edge");
   a_msb_gap: assert property (s_slot_start |=> !sdo_r)
      else $error("no one-bit gap before msb");
   a_pad_zero: assert property (p_fall && (p_idx[4:0] > CPS_WORD_MAX)
      && (mode_l != CPS_OFF) |=> !sdo_r) else $error("padding bit not zero");
   a_bit_count: assert property (p_fall && !pulse_m && (mode_l != CPS_OFF)
      && !$past(mode_l == CPS_OFF) |-> p_idx == last_idx_r + 6'd1)
      else $error("bit index skipped");
   a_left_low: assert property (s_slot_start |=> fclk_p_r == $past(p_idx[5]))
      else $error("frame clock level wrong for slot");
   a_pulse_one: assert property (s_pulse_start |=> syn_p_r [*1] ##0
      (syn_p_r throughout (!p_fall [*1])))
      else $error("sync pulse not raised");
   a_pulse_end: assert property (p_fall && (p_idx == 6'h01) && (mode_l == CPS_PULSE)
      |=> !syn_p_r) else $error("sync pulse longer than one bit");
   a_sec_req: assert property ((mode_l == CPS_PULSE) |=>
      !secondary_channel_pin_oe_n && secondary_channel_pin_o == $past(cfg_l_r.ctrl.sreq))
      else $error("request pin not driven from control");
   a_rec_clock: assert property ((mode_l == CPS_I2S5) |=>
      port_codec_reset_pin == $past(r_bclk)) else $error("record bit clock not on pin");
endmodule : cps_codec_port

// ### verif/cps_codec_model.sv
`timescale 1ns/100ps
// =========================================================
// codec model: two stereo adcs on one bit and frame clock
module cps_codec_model #(
   parameter logic [23:0] PL = 24'ha5c3e1,
   parameter logic [23:0] PR = 24'h5a3c1e,
   parameter logic [23:0] SL = 24'h123456,
   parameter logic [23:0] SR = 24'h89abcd
) (
   input  wire logic bclk,
   input  wire logic left_right_frame_clock,
   output logic      sd_pri,
   output logic      sd_sec
);
   int   cnt  = 0;
   logic last = 1'b0;
   initial begin
      sd_pri = 1'b0;
      sd_sec = 1'b0;
   end
   // wait past the frame clock update so slot start is seen on time
   always @(negedge bclk) begin
      #40;
      cnt = (left_right_frame_clock != last) ? 0 : cnt + 1;
      last = left_right_frame_clock;
      // msb one bit after frame edge, zeros past the word
      sd_pri <= (cnt >= 1 && cnt <= 24) ? (left_right_frame_clock ? PR[24-cnt] : PL[24-cnt]) : 1'b0;
      sd_sec <= (cnt >= 1 && cnt <= 24) ? (left_right_frame_clock ? SR[24-cnt] : SL[24-cnt]) : 1'b0;
   end
endmodule : cps_codec_model

// ### verif/tb_cps_codec_port.sv
`timescale 1ns/100ps
module tb_cps_codec_port;
   import cps_pkg::*;
   localparam logic [23:0] TL = 24'hc0ffee;
   localparam logic [23:0] TR = 24'h7e5d01;
   logic        ref_clk = 1'b0;
   logic        mclk    = 1'b0;
   logic        rst     = 1'b1;
   logic [7:0]  addr    = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        wr      = 1'b0;
   logic        rd      = 1'b0;
   logic [31:0] rdata, rd_v;
   logic        sync_o, sync_oe_n, bclk, dout, crst_pin, sec_o, sec_oe_n, sd_pri, sd_sec;
   int          failures = 0;
   int          tests_run = 0;
   int          cyc = 0;
   // =========================================================
   // clocks, unrelated in phase
   initial forever #2.5 ref_clk = ~ref_clk;
   initial begin
      #7.3;
      forever #16 mclk = ~mclk;
   end
   cps_codec_port dut (
      .ref_clk(ref_clk), .rst(rst), .port_master_clk(mclk), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .port_sync_pin_o(sync_o), .port_sync_pin_oe_n(sync_oe_n), .port_sync_pin_i(1'b0),
      .port_bit_clock_pin(bclk), .port_data_out_pin(dout), .port_data_in_pin(sd_pri),
      .port_codec_reset_pin(crst_pin), .secondary_channel_pin_o(sec_o),
      .secondary_channel_pin_oe_n(sec_oe_n),
      .secondary_channel_pin_i(sec_oe_n ? sd_sec : sec_o)
   );
   cps_codec_model codec (.bclk(bclk), .left_right_frame_clock(sync_o), .sd_pri(sd_pri), .sd_sec(sd_sec));
   // =========================================================
   // shared tasks
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1 rd_v = rdata;
   endtask : rreg
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   // one full output frame after the tx words have reached the shifter
   task automatic t_frame(input int w);
      logic [63:0] d, s;
      logic [23:0] word;
      int          k;
      repeat (3) @(negedge sync_o);
      check(bclk, 1'b0);
      for (int i = 0; i < 64; i++) begin
         @(posedge bclk);
         d[i] = dout;
         s[i] = sync_o;
      end
      check(s, {{32{1'b1}}, 32'h0});
      for (int i = 0; i < 64; i++) begin
         k = i % 32;
         word = (i < 32) ? TL : TR;
         check(d[i], (k >= 1 && k <= w) ? word[24-k] : 1'b0);
      end
   endtask : t_frame
   // =========================================================
   // scenarios
   task automatic t_reset;
      check({sync_o, sync_oe_n, bclk, dout, crst_pin, sec_o, sec_oe_n}, 7'h01);
      repeat (40) @(posedge ref_clk);
      check(bclk, 1'b0);
      rreg(CPS_OFS_CTRL);
      check(rd_v, 32'h0);
      rreg(CPS_OFS_DIV);
      check(rd_v, {16'h0, CPS_DIV_RST});
      wreg(8'h3c, 32'hffffffff);
      rreg(8'h3c);
      check(rd_v, 32'h0);
   endtask : t_reset
   task automatic t_mode4;
      logic [23:0] exp_rx [4];
      exp_rx = '{24'ha5c3e1, 24'h123456, 24'h5a3c1e, 24'h89abcd};
      wreg(CPS_OFS_TX0, {8'h0, TL});
      wreg(CPS_OFS_TX1, {8'h0, TR});
      wreg(CPS_OFS_CTRL, 32'h0d);
      rreg(CPS_OFS_STAT);
      check(rd_v[23:16], 8'hf3);
      check(sec_oe_n, 1'b1);
      t_frame(24);
      @(negedge sync_o);
      repeat (40) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         rreg(CPS_OFS_RX0 + 8'(4 * i));
         check(rd_v[23:0], exp_rx[i]);
      end
   endtask : t_mode4
   task automatic t_width16;
      wreg(CPS_OFS_CTRL, 32'h00);
      wreg(CPS_OFS_CTRL, 32'h01);
      t_frame(16);
   endtask : t_width16
   // byte reversal on the record words, codec reset level on its pin
   task automatic t_byte_order_reverse;
      wreg(CPS_OFS_CTRL, 32'h00);
      wreg(CPS_OFS_CTRL, 32'h9d);
      repeat (5) @(negedge sync_o);
      check(crst_pin, 1'b1);
      repeat (40) @(posedge ref_clk);
      rreg(CPS_OFS_RX0);
      check(rd_v[23:0], 24'he1c3a5);
      rreg(CPS_OFS_RX3);
      check(rd_v[23:0], 24'hcdab89);
   endtask : t_byte_order_reverse
   task automatic t_other;
      wreg(CPS_OFS_CTRL, 32'h00);
      wreg(CPS_OFS_CTRL, 32'h43);
      repeat (20) @(posedge ref_clk);
      check({sec_o, sec_oe_n, sync_oe_n}, 3'b100);
      @(posedge sync_o);
      @(posedge bclk);
      check(sync_o, 1'b1);
      @(posedge bclk);
      check(sync_o, 1'b0);
      wreg(CPS_OFS_CTRL, 32'h23);
      repeat (20) @(posedge ref_clk);
      check(sync_oe_n, 1'b1);
      wreg(CPS_OFS_CTRL, 32'h00);
      wreg(CPS_OFS_CTRL, 32'h0e);
      @(posedge crst_pin);
      check(sec_oe_n, 1'b0);
      rreg(CPS_OFS_STAT);
      check(rd_v[23:16], 8'h33);
   endtask : t_other
   // =========================================================
   // hang guard, well above the four to five frames needed per test
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         report_and_stop;
      end
   end
   // reset spans both clock domains before the first access
   initial begin
      repeat (3) @(posedge mclk);
      @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_reset;
      t_mode4;
      t_width16;
      t_byte_order_reverse;
      t_other;
      report_and_stop;
   end
endmodule : tb_cps_codec_port
